/* rtl/ptv_trip_vote.sv */
// containment pressure trip voting, manual controls, lamps and register slave
// assumes pin inputs are asynchronous and AXI4-Lite comes from aclk logic
`timescale 1ns/1ps
`include "ptv_map.svh"
module ptv_trip_vote #(
  parameter int SEC_CYCLES  = `PTV_SEC_MS * `PTV_CLK_KHZ,
  parameter int RESP_CYCLES = `PTV_RESP_MS * `PTV_CLK_KHZ
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [15:0] press_a,
  input  wire logic [15:0] press_b,
  input  wire logic [15:0] press_c,
  input  wire logic [1:0]  pb_trip,
  input  wire logic [1:0]  pb_reset,
  input  wire logic [1:0]  pb_manual,
  input  wire logic [1:0]  pb_auto,
  input  wire logic [7:0]  field_status,
  output logic [1:0]       actuation_output_contact,
  output logic             building_high_pressure_trip,
  output logic [2:0]       channel_trip,
  output logic [1:0]       lamp_trip,
  output logic [1:0]       lamp_auto,
  output logic [1:0]       lamp_manual,
  output logic [7:0]       status_lamp_odd,
  output logic [7:0]       status_lamp_even,
  output logic [7:0]       plant_status,
  output logic             irq
);
  function automatic ptv_pkg::ptv_press_t clamp_press(input ptv_pkg::ptv_press_t p);
    if (p < $signed(`PTV_P_MIN)) return $signed(`PTV_P_MIN);
    if (p > $signed(`PTV_P_MAX)) return $signed(`PTV_P_MAX);
    return p;
  endfunction : clamp_press

  function automatic ptv_pkg::ptv_press_t second_highest(
    input ptv_pkg::ptv_press_t a, input ptv_pkg::ptv_press_t b, input ptv_pkg::ptv_press_t c);
    ptv_pkg::ptv_press_t hi;
    ptv_pkg::ptv_press_t lo;
    hi = (a > b) ? a : b;
    lo = (a > b) ? b : a;
    hi = (hi < c) ? hi : c;
    return (lo > hi) ? lo : hi;
  endfunction : second_highest

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : merge

  // two-stage synchronisers; buttons get a third stage for edges
  logic [47:0] p1_press;
  logic [47:0] p2_press;
  logic [7:0]  p1_btn;
  logic [7:0]  p2_btn;
  logic [7:0]  p3_btn;
  logic [7:0]  p1_field;
  logic [7:0]  p2_field;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p1_press <= 48'h0;
      p2_press <= 48'h0;
      p1_btn   <= 8'h00;
      p2_btn   <= 8'h00;
      p3_btn   <= 8'h00;
      p1_field <= 8'h00;
      p2_field <= 8'h00;
    end else begin
      p1_press <= {press_c, press_b, press_a};
      p2_press <= p1_press;
      p1_btn   <= {pb_auto, pb_manual, pb_reset, pb_trip};
      p2_btn   <= p1_btn;
      p3_btn   <= p2_btn;
      p1_field <= field_status;
      p2_field <= p1_field;
    end
  end

  logic [7:0] btn_edge;
  logic [1:0] trp_edge;
  logic [1:0] rst_edge;
  logic [1:0] man_edge;
  logic [1:0] aut_edge;
  assign btn_edge = p2_btn & ~p3_btn;
  assign trp_edge = btn_edge[1:0];
  assign rst_edge = btn_edge[3:2];
  assign man_edge = btn_edge[5:4];
  assign aut_edge = btn_edge[7:6];

  // register bus state
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_q;
  logic [31:0] wd_q;
  logic [3:0]  ws_q;
  logic        next_aw_held;
  logic        next_w_held;
  logic [7:0]  next_aw_q;
  logic [31:0] next_wd_q;
  logic [3:0]  next_ws_q;
  logic        next_awready;
  logic        next_wready;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_arready;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        wr_go;
  logic        rd_go;
  // software registers
  logic [15:0] setpoint;
  logic [15:0] rst_thr;
  logic [9:0]  delay_s [2];
  logic [3:0]  ev;
  logic [3:0]  ev_mask;
  logic [15:0] next_setpoint;
  logic [15:0] next_rst_thr;
  logic [9:0]  next_delay_s [2];
  logic [3:0]  next_ev;
  logic [3:0]  next_ev_mask;
  logic [3:0]  ev_set;
  logic [3:0]  ev_clr;
  logic [31:0] tmp;
  // protection core
  ptv_pkg::ptv_press_t sh [3];
  ptv_pkg::ptv_press_t next_sh [3];
  ptv_pkg::ptv_mode_e  mode [2];
  ptv_pkg::ptv_mode_e  next_mode [2];
  logic [2:0]  next_channel_trip;
  logic        vote;
  logic [1:0]  act_latch;
  logic [1:0]  next_act_latch;
  logic [1:0]  man_trip;
  logic [1:0]  next_man_trip;
  logic [1:0]  demand;
  logic [1:0]  closed;
  logic [31:0] sec_cnt;
  logic        tick;

  assign wr_go = aw_held && w_held && !bvalid;
  assign rd_go = arvalid && arready;

  always_comb begin
    next_aw_held = aw_held;
    next_aw_q    = aw_q;
    next_w_held  = w_held;
    next_wd_q    = wd_q;
    next_ws_q    = ws_q;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_q    = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_wd_q   = wdata;
      next_ws_q   = wstrb;
    end
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
    end
    next_bvalid  = wr_go || (bvalid && !bready);
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
    next_bresp   = bresp;
    if (wr_go) begin
      if (aw_q[7:5] != 3'h0 || aw_q[1:0] != 2'h0) next_bresp = `PTV_RESP_SLVERR;
      else next_bresp = `PTV_RESP_OKAY;
    end
    next_rvalid  = rd_go || (rvalid && !rready);
    next_arready = !next_rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (rd_go) begin
      next_rresp = `PTV_RESP_OKAY;
      if (araddr == `PTV_ADDR_SETPOINT) next_rdata = {16'h0, setpoint};
      else if (araddr == `PTV_ADDR_RST_THR) next_rdata = {16'h0, rst_thr};
      else if (araddr == `PTV_ADDR_DELAY5) next_rdata = {22'h0, delay_s[0]};
      else if (araddr == `PTV_ADDR_DELAY6) next_rdata = {22'h0, delay_s[1]};
      else if (araddr == `PTV_ADDR_STATUS) next_rdata = {16'h0, building_high_pressure_trip,
          lamp_manual, man_trip, act_latch, actuation_output_contact, 4'h0, channel_trip};
      else if (araddr == `PTV_ADDR_EVENT) next_rdata = {28'h0, ev};
      else if (araddr == `PTV_ADDR_MASK) next_rdata = {28'h0, ev_mask};
      else if (araddr == `PTV_ADDR_FIELD) next_rdata = {24'h0, p2_field};
      else begin
        next_rdata = 32'h0;
        next_rresp = `PTV_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_q    <= 8'h00;
      wd_q    <= 32'h0;
      ws_q    <= 4'h0;
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= `PTV_RESP_OKAY;
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= `PTV_RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      aw_q    <= next_aw_q;
      wd_q    <= next_wd_q;
      ws_q    <= next_ws_q;
      awready <= next_awready;
      wready  <= next_wready;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      arready <= next_arready;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  // adjustable values; range checks belong to the operator screen [R7]
  always_comb begin
    next_setpoint   = setpoint;
    next_rst_thr    = rst_thr;
    next_delay_s[0] = delay_s[0];
    next_delay_s[1] = delay_s[1];
    next_ev_mask    = ev_mask;
    tmp             = 32'h0;
    if (wr_go) begin
      if (aw_q == `PTV_ADDR_SETPOINT) begin
        tmp           = merge({16'h0, setpoint}, wd_q, ws_q);
        next_setpoint = tmp[15:0]; // [R6]
      end else if (aw_q == `PTV_ADDR_RST_THR) begin
        tmp          = merge({16'h0, rst_thr}, wd_q, ws_q);
        next_rst_thr = tmp[15:0]; // [R5]
      end else if (aw_q == `PTV_ADDR_DELAY5 || aw_q == `PTV_ADDR_DELAY6) begin
        tmp = merge({22'h0, delay_s[aw_q[2]]}, wd_q, ws_q);
        // longer requests saturate at fifteen minutes
        next_delay_s[aw_q[2]] = (tmp > 32'(`PTV_DELAY_MAX)) ? `PTV_DELAY_MAX : tmp[9:0]; // [R14]
      end else if (aw_q == `PTV_ADDR_MASK) begin
        tmp          = merge({28'h0, ev_mask}, wd_q, ws_q);
        next_ev_mask = tmp[3:0];
      end
    end
    ev_set = 4'h0;
    ev_set[`PTV_EV_VOTE]  = vote && !building_high_pressure_trip;
    ev_set[`PTV_EV_MTRIP] = |trp_edge;
    ev_set[`PTV_EV_RESET] = |rst_edge;
    ev_set[`PTV_EV_MODE]  = |(man_edge | aut_edge);
    ev_clr  = (rd_go && araddr == `PTV_ADDR_EVENT) ? ev : 4'h0;
    // a new event in the clearing cycle survives
    next_ev = (ev & ~ev_clr) | ev_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      setpoint   <= `PTV_SETPOINT_RST;
      rst_thr    <= `PTV_RST_THR_RST;
      delay_s[0] <= `PTV_DELAY_RST;
      delay_s[1] <= `PTV_DELAY_RST;
      ev_mask    <= 4'h0;
      ev         <= 4'h0;
      irq        <= 1'b0;
    end else begin
      setpoint   <= next_setpoint;
      rst_thr    <= next_rst_thr;
      delay_s[0] <= next_delay_s[0];
      delay_s[1] <= next_delay_s[1];
      ev_mask    <= next_ev_mask;
      ev         <= next_ev;
      irq        <= |(next_ev & next_ev_mask);
    end
  end

  // vote has no bypass input by design [R17]
  assign vote = (channel_trip[0] && channel_trip[1]) || (channel_trip[0] && channel_trip[2]) ||
                (channel_trip[1] && channel_trip[2]); // [R3]

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      // each instrument channel selects from all three values [R1]
      next_sh[i] = second_highest(clamp_press(p2_press[15:0]), clamp_press(p2_press[31:16]),
                                  clamp_press(p2_press[47:32])); // [R6]
      next_channel_trip[i] = channel_trip[i];
      if (sh[i] >= $signed(setpoint)) next_channel_trip[i] = 1'b1; // [R2]
      else if (sh[i] < $signed(rst_thr)) next_channel_trip[i] = 1'b0; // [R5]
    end
    for (int j = 0; j < 2; j++) begin
      // holding vote re-latches, so trip cannot be reset while still voted
      next_act_latch[j] = vote || (act_latch[j] && !rst_edge[j]); // [R3] [R9] [R18]
      next_man_trip[j]  = trp_edge[j] || (man_trip[j] && !rst_edge[j]); // [R8] [R9] [R12]
      next_mode[j] = mode[j];
      case (mode[j]) // one selector per logic channel [R13]
        ptv_pkg::PTV_MODE_AUTO:   if (man_edge[j]) next_mode[j] = ptv_pkg::PTV_MODE_MANUAL; // [R10]
        ptv_pkg::PTV_MODE_MANUAL: if (aut_edge[j] || rst_edge[j]) next_mode[j] = ptv_pkg::PTV_MODE_AUTO; // [R11]
        default:                  next_mode[j] = ptv_pkg::PTV_MODE_AUTO;
      endcase
      // reset outranks a manual press landing in the same cycle
      if (rst_edge[j]) next_mode[j] = ptv_pkg::PTV_MODE_AUTO; // [R11]
      demand[j] = act_latch[j] && mode[j] == ptv_pkg::PTV_MODE_AUTO; // [R10]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 3; i++) sh[i] <= 16'sh0000;
      mode[0]                     <= ptv_pkg::PTV_MODE_AUTO;
      mode[1]                     <= ptv_pkg::PTV_MODE_AUTO;
      channel_trip                <= 3'h0;
      act_latch                   <= 2'h0;
      man_trip                    <= 2'h0;
      building_high_pressure_trip <= 1'b0;
      actuation_output_contact    <= 2'h0;
      lamp_trip                   <= 2'h0;
      lamp_auto                   <= 2'h3;
      lamp_manual                 <= 2'h0;
      status_lamp_odd             <= 8'h00;
      status_lamp_even            <= 8'h00;
      plant_status                <= 8'h00;
    end else begin
      for (int i = 0; i < 3; i++) sh[i] <= next_sh[i];
      mode[0]                     <= next_mode[0];
      mode[1]                     <= next_mode[1];
      channel_trip                <= next_channel_trip;
      act_latch                   <= next_act_latch;
      man_trip                    <= next_man_trip;
      building_high_pressure_trip <= vote; // [R4]
      // manual trip skips the delay and the mode selector [R8]
      actuation_output_contact    <= closed | man_trip;
      lamp_trip                   <= next_act_latch | next_man_trip; // [R11]
      for (int j = 0; j < 2; j++) begin
        lamp_auto[j]   <= next_mode[j] == ptv_pkg::PTV_MODE_AUTO; // [R10]
        lamp_manual[j] <= next_mode[j] == ptv_pkg::PTV_MODE_MANUAL; // [R10] [R11]
      end
      status_lamp_odd             <= p2_field; // [R16]
      status_lamp_even            <= p2_field; // [R16]
      plant_status                <= p2_field; // [R16]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) sec_cnt <= 32'h0;
    else if (tick) sec_cnt <= 32'h0;
    else sec_cnt <= sec_cnt + 32'h1;
  end
  assign tick = sec_cnt == 32'(SEC_CYCLES - 1);

  for (genvar g = 0; g < 2; g++) begin : g_delay
    ptv_close_delay i_ptv_close_delay (
      .aclk    (aclk),
      .aresetn (aresetn),
      .demand  (demand[g]),
      .tick    (tick),
      .delay_s (delay_s[g]),
      .closed  (closed[g])
    );
  end

  // helper: cycles a voted trip has waited for contact 5 with zero delay
  logic [31:0] wait_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn || !(vote && demand[0] && delay_s[0] == 10'h000) || actuation_output_contact[0])
      wait_cnt <= 32'h0;
    else wait_cnt <= wait_cnt + 32'h1;
  end

  property p_resp;
    @(posedge aclk) disable iff (!aresetn) wait_cnt < 32'(RESP_CYCLES);
  endproperty
  a_resp: assert property (p_resp) else $error("response time exceeded"); // [R15]

  property p_second;
    @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> sh[1] == second_highest(clamp_press($past(p2_press[15:0])),
        clamp_press($past(p2_press[31:16])), clamp_press($past(p2_press[47:32])));
  endproperty
  a_second: assert property (p_second) else $error("wrong second-highest pressure"); // [R1]

  property p_trip_set;
    @(posedge aclk) disable iff (!aresetn) sh[0] >= $signed(setpoint) |=> channel_trip[0];
  endproperty
  a_trip_set: assert property (p_trip_set) else $error("channel did not trip"); // [R2]

  property p_trip_clr;
    @(posedge aclk) disable iff (!aresetn)
      sh[2] < $signed(rst_thr) && sh[2] < $signed(setpoint) |=> !channel_trip[2];
  endproperty
  a_trip_clr: assert property (p_trip_clr) else $error("channel did not auto-reset"); // [R5]

  property p_vote;
    @(posedge aclk) disable iff (!aresetn)
      channel_trip[1] && channel_trip[2] |=> act_latch == 2'h3 && building_high_pressure_trip;
  endproperty
  a_vote: assert property (p_vote) else $error("two-of-three vote missed"); // [R3] [R4]

  property p_man;
    @(posedge aclk) disable iff (!aresetn) trp_edge[0] |-> ##2 actuation_output_contact[0];
  endproperty
  a_man: assert property (p_man) else $error("manual trip did not energise"); // [R8] [R12]

  property p_reset;
    @(posedge aclk) disable iff (!aresetn)
      rst_edge[0] && !vote && !trp_edge[0] |=> !man_trip[0] && !lamp_trip[0] && !lamp_manual[0];
  endproperty
  a_reset: assert property (p_reset) else $error("reset left trip or lamps on"); // [R9] [R11]

  property p_manual;
    @(posedge aclk) disable iff (!aresetn)
      (mode[1] == ptv_pkg::PTV_MODE_MANUAL && !man_trip[1]) [*3] |-> !actuation_output_contact[1];
  endproperty
  a_manual: assert property (p_manual) else $error("manual mode kept contact"); // [R10]

  property p_latch;
    @(posedge aclk) disable iff (!aresetn) act_latch[1] && !rst_edge[1] |=> act_latch[1];
  endproperty
  a_latch: assert property (p_latch) else $error("actuation dropped without reset"); // [R18]

  property p_field;
    @(posedge aclk) disable iff (!aresetn)
      status_lamp_odd == status_lamp_even && plant_status == status_lamp_odd;
  endproperty
  a_field: assert property (p_field) else $error("field status differs by cabinet"); // [R16]
endmodule : ptv_trip_vote

/* rtl/ptv_map.svh */
// register offsets, reset values and timing counts of the pressure trip voting block
// assumes a 25 MHz aclk and pressures in hundredths of a psig, signed
//
// Contract
// R1: each channel picks the second-highest of the three pressure values
// R2: a channel trips when second-highest pressure reaches the rising setpoint
// R3: two or more tripped channels actuate output channels 5 and 6
// R4: the high-pressure trip is also sent out to actuation channels 1 to 4
// R5: a channel trip clears by itself below the auto-reset threshold
// R6: pressure spans -15 to +15 psig; setpoint and threshold are adjustable
// R7: the operator parameter screen rejects values outside their range limits
// R8: a manual trip press energises that channel's relays, bypassing automatic logic
// R9: a reset press clears that channel's manual or automatic trip; here the automatic trip re-latches while the vote holds
// R10: a manual press selects manual mode, swaps lamps, drops automatic contacts
// R11: a reset press turns off that channel's trip and manual lamps; here the trip lamp stays lit while the vote holds
// R12: after a reset, another trip press actuates the channel again
// R13: auto and manual selection exists once per logic channel
// R14: each output contact closes after an adjustable 0 to 15 minute delay
// R15: input to output response stays below 500 ms
// R16: shared field status drives both cabinets' lamps and plant status
// R17: there is no bypass or inhibit; voting is always active
// R18: output actuation stays latched until that channel's reset press
`ifndef PTV_MAP_SVH
`define PTV_MAP_SVH

`define PTV_ADDR_SETPOINT  8'h00
`define PTV_ADDR_RST_THR   8'h04
`define PTV_ADDR_DELAY5    8'h08
`define PTV_ADDR_DELAY6    8'h0c
`define PTV_ADDR_STATUS    8'h10
`define PTV_ADDR_EVENT     8'h14
`define PTV_ADDR_MASK      8'h18
`define PTV_ADDR_FIELD     8'h1c

`define PTV_SETPOINT_RST   16'h012c
`define PTV_RST_THR_RST    16'h0122
`define PTV_P_MIN          16'hfa24
`define PTV_P_MAX          16'h05dc
`define PTV_DELAY_RST      10'h000
`define PTV_DELAY_MAX      10'h384

`define PTV_EV_VOTE        0
`define PTV_EV_MTRIP       1
`define PTV_EV_RESET       2
`define PTV_EV_MODE        3

`define PTV_RESP_OKAY      2'h0
`define PTV_RESP_SLVERR    2'h2

`define PTV_CLK_KHZ        25000
`define PTV_SEC_MS         1000
`define PTV_RESP_MS        500

`endif

/* rtl/ptv_pkg.sv */
// types shared by the pressure trip voting files
// assumes ptv_map.svh supplies the numbers
package ptv_pkg;
  typedef enum logic [1:0] {
    PTV_MODE_AUTO   = 2'b01,
    PTV_MODE_MANUAL = 2'b10
  } ptv_mode_e;
  typedef logic signed [15:0] ptv_press_t;
endpackage : ptv_pkg

/* rtl/ptv_close_delay.sv */
// closure delay of one actuation output contact
// assumes tick is a one-cycle pulse once per second from the parent
`timescale 1ns/1ps
`include "ptv_map.svh"
module ptv_close_delay (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       demand,
  input  wire logic       tick,
  input  wire logic [9:0] delay_s,
  output logic            closed
);
  logic [9:0] count;
  logic [9:0] next_count;
  logic       next_closed;

  always_comb begin
    next_count  = count;
    next_closed = closed;
    if (!demand) begin
      next_count  = 10'h000;
      next_closed = 1'b0;
    end else if (count >= delay_s) begin
      next_closed = 1'b1; // [R14]
    end else if (tick) begin
      next_count = count + 10'h001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count  <= 10'h000;
      closed <= 1'b0;
    end else begin
      count  <= next_count;
      closed <= next_closed;
    end
  end

  property p_zero_delay;
    @(posedge aclk) disable iff (!aresetn)
      demand && delay_s == 10'h000 |=> closed;
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero delay did not close"); // [R14]

  property p_open_idle;
    @(posedge aclk) disable iff (!aresetn)
      !demand |=> !closed;
  endproperty
  a_open_idle: assert property (p_open_idle) else $error("contact closed without demand"); // [R14]
endmodule : ptv_close_delay

/* tb/ptv_field_model.sv */
// field side: pressure transmitters, pushbuttons and shared checkback
// assumes one bench process calls these tasks in step with aclk
`timescale 1ns/1ps
module ptv_field_model (
  input  wire logic   aclk,
  output logic [15:0] press_a,
  output logic [15:0] press_b,
  output logic [15:0] press_c,
  output logic [1:0]  pb_trip,
  output logic [1:0]  pb_reset,
  output logic [1:0]  pb_manual,
  output logic [1:0]  pb_auto,
  output logic [7:0]  field_status
);
  initial begin
    {press_a, press_b, press_c} = 48'h0;
    {pb_trip, pb_reset, pb_manual, pb_auto} = 8'h00;
    field_status = 8'h00;
  end
  // held well past the two sync flops, then settled past the pipeline
  task automatic push(input int k, input logic [1:0] ch);
    @(posedge aclk);
    case (k)
      0: pb_trip <= ch;
      1: pb_reset <= ch;
      2: pb_manual <= ch;
      default: pb_auto <= ch;
    endcase
    repeat (6) @(posedge aclk);
    {pb_trip, pb_reset, pb_manual, pb_auto} <= 8'h00;
    repeat (30) @(posedge aclk);
  endtask : push
  task automatic set_p(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    @(posedge aclk);
    {press_a, press_b, press_c} <= {a, b, c};
    repeat (30) @(posedge aclk);
  endtask : set_p
  task automatic set_f(input logic [7:0] f);
    @(posedge aclk);
    field_status <= f;
    repeat (10) @(posedge aclk);
  endtask : set_f
endmodule : ptv_field_model

/* tb/ptv_trip_vote_tb.sv */
// bench of the pressure trip voting block over AXI4-Lite
// assumes the field model drives the pins; one-second tick shortened to 4 cycles
`timescale 1ns/1ps
`include "ptv_map.svh"
module ptv_trip_vote_tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq, hpt;
  logic [7:0]  awaddr, araddr, field_status, sl_odd, sl_even, plant;
  logic [31:0] wdata, rdata;
  logic [15:0] press_a, press_b, press_c;
  logic [1:0]  bresp, rresp, pb_trip, pb_reset, pb_manual, pb_auto, contact, l_trip, l_auto, l_man;
  logic [2:0]  ch_trip;
  int          checks, error_cnt;

  ptv_trip_vote #(.SEC_CYCLES(4)) i_ptv_trip_vote (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .press_a(press_a), .press_b(press_b),
    .press_c(press_c), .pb_trip(pb_trip), .pb_reset(pb_reset), .pb_manual(pb_manual),
    .pb_auto(pb_auto), .field_status(field_status), .actuation_output_contact(contact),
    .building_high_pressure_trip(hpt), .channel_trip(ch_trip), .lamp_trip(l_trip),
    .lamp_auto(l_auto), .lamp_manual(l_man), .status_lamp_odd(sl_odd),
    .status_lamp_even(sl_even), .plant_status(plant), .irq(irq));
  ptv_field_model i_ptv_field_model (.aclk(aclk), .press_a(press_a), .press_b(press_b),
    .press_c(press_c), .pb_trip(pb_trip), .pb_reset(pb_reset), .pb_manual(pb_manual),
    .pb_auto(pb_auto), .field_status(field_status));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic hang;
    error_cnt++;
    $display("CHECK FAILED at %0t: bus answer never came", $time);
    test_done();
  endtask : hang
  // both channels offered together; each released once its ready is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    if (!bvalid) hang();
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er}, "write response");
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    if (!rvalid) hang();
    rready <= 1'b0;
    chk(rdata, e, "read data");
    chk({30'h0, rresp}, {30'h0, er}, "read response");
  endtask : rd

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    {checks, error_cnt} = 64'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`PTV_ADDR_SETPOINT, {16'h0, `PTV_SETPOINT_RST}, `PTV_RESP_OKAY);
    rd(`PTV_ADDR_RST_THR, {16'h0, `PTV_RST_THR_RST}, `PTV_RESP_OKAY);
    rd(8'h20, 32'h0, `PTV_RESP_SLVERR);
    wr(8'h20, 32'h1, `PTV_RESP_SLVERR);
    wr(`PTV_ADDR_SETPOINT, 32'h12c, `PTV_RESP_OKAY);
    wr(`PTV_ADDR_MASK, 32'h1, `PTV_RESP_OKAY);
    chk({30'h0, l_auto}, 32'h3, "auto lamps at reset");
    $display("test registers done");
    // largest alone must not trip: the middle value decides
    i_ptv_field_model.set_p(16'd400, 16'd299, 16'd100);
    chk({29'h0, ch_trip}, 32'h0, "below setpoint");
    i_ptv_field_model.set_p(16'd400, 16'd300, 16'd100);
    chk({29'h0, ch_trip}, 32'h7, "trip at setpoint");
    chk({31'h0, hpt}, 32'h1, "forwarded trip");
    chk({30'h0, contact}, 32'h3, "vote contacts");
    chk({31'h0, irq}, 32'h1, "irq raised");
    rd(`PTV_ADDR_EVENT, 32'h1, `PTV_RESP_OKAY);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    $display("test vote done");
    i_ptv_field_model.set_p(16'd295, 16'd295, 16'd295);
    chk({29'h0, ch_trip}, 32'h7, "hold above threshold");
    i_ptv_field_model.set_p(16'd289, 16'h0, 16'h0);
    chk({29'h0, ch_trip}, 32'h0, "auto clear");
    chk({30'h0, contact}, 32'h3, "latched contacts");
    rd(`PTV_ADDR_STATUS, 32'h780, `PTV_RESP_OKAY);
    i_ptv_field_model.push(1, 2'b01);
    chk({30'h0, contact}, 32'h2, "reset ch5");
    chk({31'h0, l_trip[0]}, 32'h0, "trip lamp off");
    i_ptv_field_model.push(0, 2'b01);
    chk({30'h0, contact}, 32'h3, "manual trip ch5");
    chk({31'h0, irq}, 32'h0, "masked events");
    rd(`PTV_ADDR_EVENT, 32'h6, `PTV_RESP_OKAY);
    i_ptv_field_model.push(1, 2'b01);
    $display("test reset done");
    i_ptv_field_model.push(2, 2'b10);
    chk({26'h0, l_auto, l_man, contact}, 32'h18, "manual ch6");
    i_ptv_field_model.push(3, 2'b10);
    chk({30'h0, l_auto}, 32'h3, "auto again");
    i_ptv_field_model.push(2, 2'b10);
    i_ptv_field_model.push(1, 2'b10);
    chk({28'h0, l_auto, l_man}, 32'hc, "reset lamps ch6");
    $display("test modes done");
    wr(`PTV_ADDR_DELAY6, 32'd1000, `PTV_RESP_OKAY);
    rd(`PTV_ADDR_DELAY6, {22'h0, `PTV_DELAY_MAX}, `PTV_RESP_OKAY);
    wr(`PTV_ADDR_DELAY6, 32'h0, `PTV_RESP_OKAY);
    wr(`PTV_ADDR_DELAY5, 32'd10, `PTV_RESP_OKAY);
    i_ptv_field_model.set_p(16'd400, 16'd400, 16'd400);
    chk({30'h0, contact}, 32'h2, "ch5 still delayed");
    repeat (60) @(posedge aclk);
    chk({30'h0, contact}, 32'h3, "ch5 closed after delay");
    $display("test delay done");
    i_ptv_field_model.set_f(8'ha5);
    chk({8'h0, sl_odd, sl_even, plant}, 32'h00a5a5a5, "field status");
    rd(`PTV_ADDR_FIELD, 32'ha5, `PTV_RESP_OKAY);
    $display("test field done");
    test_done();
  end
endmodule : ptv_trip_vote_tb
